// [sia_status_interrupt_aggregator.sv]
// top: sticky interrupt flags, mask, combine and status pin routing
//
// Overview of operation
// - any status pin can carry the interrupt
// - enabled logic accepts any source combination
// - polarity high sets flag on rising edge
// - polarity low sets flag on falling edge
// - masked flags set but never drive output
// - unmasked flags combined by AND or OR
// - interrupt routable to either status pin
// - write-one clear drops output, self-clears
// - per pin select, driver type, polarity
// - phase lock loss follows hysteresis thresholds
`timescale 1ns/1ps
module sia_status_interrupt_aggregator #(
    parameter int N = sia_pkg::NUM_SRC,
    parameter int P = sia_pkg::NUM_PINS,
    parameter int PW = sia_pkg::PHERR_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [N-2:0] live_status,
    input wire logic [PW-1:0] phase_err,
    input wire logic [PW-1:0] lock_thr,
    input wire logic [PW-1:0] unlock_thr,
    input wire logic intr_enable,
    input wire logic [N-1:0] src_enable,
    input wire logic [N-1:0] intr_polarity,
    input wire logic [N-1:0] intr_mask,
    input wire logic comb_and,
    input wire logic interrupt_clear,
    input wire logic [P*sia_pkg::SEL_W-1:0] pin_sel,
    input wire logic [P-1:0] pin_invert,
    input wire logic [P-1:0] pin_open_drain,
    output logic [N-1:0] sticky_flags,
    output logic [N-1:0] live_flags,
    output logic intr_out,
    output logic interrupt_clear_busy,
    output logic [P-1:0] status_pin_o,
    output logic [P-1:0] status_pin_oe
);
    typedef struct packed {
        logic [N-1:0] live;
        logic [N-1:0] flag;
        logic intr;
        logic clr_busy;
        logic [P-1:0] pin;
        logic [P-1:0] oe;
    } sia_state_s;

    sia_state_s st_r;
    sia_state_s st_nxt;
    logic ph_lost;
    logic [N-1:0] live_now;
    logic [N-1:0] edge_hit;
    logic [N-1:0] unmasked;
    logic comb_val;

    // pick one status signal by code
    function automatic logic sel_sig(input logic [3:0] code,
                                     input logic [N-1:0] lv,
                                     input logic irq);
        logic r;
        r = 1'b0;
        if (code == sia_pkg::SEL_INTR) begin
            r = irq;
        end else if (code < sia_pkg::SEL_INTR) begin
            r = lv[code];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // phase lock detector feeding the last source
    sia_phase_lock #(
        .W(PW)
    ) u_phase_lock (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .phase_err(phase_err),
        .lock_thr(lock_thr),
        .unlock_thr(unlock_thr),
        .phase_lock_lost(ph_lost)
    );

    ////////////////////////////////////////////////////////////////////
    // edge detect against previous sample, selected polarity
    assign live_now = {ph_lost, live_status};
    always_comb begin
        for (int i = 0; i < N; i++) begin
            edge_hit[i] = intr_polarity[i]
                ? (live_now[i] && !st_r.live[i])
                : (!live_now[i] && st_r.live[i]);
        end
        edge_hit = edge_hit & src_enable & {N{intr_enable}};
    end

    // unmasked reduction; masked bits neutral for the chosen gate
    always_comb begin
        unmasked = st_r.flag & ~intr_mask;
        if (comb_and == sia_pkg::COMB_AND) begin
            comb_val = (|(~intr_mask)) && &(st_r.flag | intr_mask);
        end else begin
            comb_val = |unmasked;
        end
    end

    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.live = live_now;
        st_nxt.clr_busy = interrupt_clear;
        if (interrupt_clear) begin
            // clear drops flags, a coincident edge still lands
            st_nxt.flag = edge_hit;
            st_nxt.intr = 1'b0;
        end else begin
            st_nxt.flag = st_r.flag | edge_hit;
            st_nxt.intr = intr_enable && comb_val;
        end
        for (int p = 0; p < P; p++) begin
            st_nxt.pin[p] = sel_sig(pin_sel[p*sia_pkg::SEL_W +:
                sia_pkg::SEL_W], st_r.live, st_r.intr)
                ^ pin_invert[p];
            // open drain drives low only, push-pull always drives
            st_nxt.oe[p] = pin_open_drain[p] ? !st_nxt.pin[p] : 1'b1;
        end
    end

    // single state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, flags read without side effect
    assign sticky_flags = st_r.flag;
    assign live_flags = st_r.live;
    assign intr_out = st_r.intr;
    assign interrupt_clear_busy = st_r.clr_busy;
    assign status_pin_o = st_r.pin;
    assign status_pin_oe = st_r.oe;

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_rise;
        @(posedge sys_clk) disable iff (!rst_n)
        intr_enable && src_enable[0] && intr_polarity[0]
            && $rose(live_now[0]) && !interrupt_clear |=> sticky_flags[0];
    endproperty
    a_rise: assert property (p_rise) else $error("rise flag missed");

    property p_fall;
        @(posedge sys_clk) disable iff (!rst_n)
        intr_enable && src_enable[1] && !intr_polarity[1]
            && $fell(live_now[1]) |=> sticky_flags[1];
    endproperty
    a_fall: assert property (p_fall) else $error("fall flag missed");

    property p_sticky;
        @(posedge sys_clk) disable iff (!rst_n)
        sticky_flags[2] && !interrupt_clear |=> sticky_flags[2];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");

    property p_mask;
        @(posedge sys_clk) disable iff (!rst_n)
        (&intr_mask) && !comb_and |=> !intr_out;
    endproperty
    a_mask: assert property (p_mask) else $error("masked flag fired");

    property p_or;
        @(posedge sys_clk) disable iff (!rst_n)
        intr_enable && !comb_and && |(sticky_flags & ~intr_mask)
            && !interrupt_clear |=> intr_out;
    endproperty
    a_or: assert property (p_or) else $error("or combine wrong");

    property p_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        interrupt_clear |=> !intr_out && interrupt_clear_busy;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");

    property p_selfclr;
        @(posedge sys_clk) disable iff (!rst_n)
        interrupt_clear ##1 !interrupt_clear |=> !interrupt_clear_busy;
    endproperty
    a_selfclr: assert property (p_selfclr) else $error("no self clear");

    property p_clrflags;
        @(posedge sys_clk) disable iff (!rst_n)
        interrupt_clear && !intr_enable |=> sticky_flags == '0;
    endproperty
    a_clrflags: assert property (p_clrflags) else $error("flags kept");

    property p_route;
        @(posedge sys_clk) disable iff (!rst_n)
        pin_sel[3:0] == sia_pkg::SEL_INTR && !pin_invert[0]
            |=> status_pin_o[0] == $past(intr_out);
    endproperty
    a_route: assert property (p_route) else $error("route wrong");

    c_intr: cover property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(intr_out));
    c_clear: cover property (@(posedge sys_clk) disable iff (!rst_n)
        intr_out ##1 interrupt_clear);
    c_and: cover property (@(posedge sys_clk) disable iff (!rst_n)
        comb_and && intr_out);
endmodule

// [sia_pkg.sv]
// package: constants for the status interrupt aggregator
package sia_pkg;
    // source count and bit positions of the status sources
    localparam int NUM_SRC = 10;
    localparam int SRC_XO_LOS = 0;
    localparam int SRC_REF_LOR = 1;
    localparam int SRC_APLL1_LOL = 2;
    localparam int SRC_APLL2_LOL = 3;
    localparam int SRC_DPLL_LOL0 = 4;
    localparam int SRC_DPLL_LOL_N = 3;
    localparam int SRC_HOLDOVER = 7;
    localparam int SRC_SWITCHOVER = 8;
    localparam int SRC_PHASE_LOL = 9;
    // status pins and selectable status signals per pin
    localparam int NUM_PINS = 2;
    localparam int SEL_W = 4;
    localparam int NUM_SEL = 12;
    // status select codes: 0..9 live sources, 10 interrupt, 11 const low
    localparam logic [3:0] SEL_INTR = 4'hA;
    localparam logic [3:0] SEL_ZERO = 4'hB;
    // combine modes
    localparam logic COMB_OR = 1'b0;
    localparam logic COMB_AND = 1'b1;
    // reset values
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_LIVE = 1'b0;
    // phase error width for the lock detector
    localparam int PHERR_W = 16;
endpackage

// [sia_phase_lock.sv]
// phase loss-of-lock detector with hysteresis
`timescale 1ns/1ps
module sia_phase_lock #(
    parameter int W = sia_pkg::PHERR_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] phase_err,
    input wire logic [W-1:0] lock_thr,
    input wire logic [W-1:0] unlock_thr,
    output logic phase_lock_lost
);
    typedef struct packed {
        logic lost;
    } sia_pl_s;

    sia_pl_s st_r;
    sia_pl_s st_nxt;

    // clear below lock threshold, set above unlock threshold
    always_comb begin
        st_nxt = st_r;
        if (phase_err < lock_thr) begin
            st_nxt.lost = 1'b0;
        end else if (phase_err > unlock_thr) begin
            st_nxt.lost = 1'b1;
        end
    end

    // state register, starts unlocked
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{lost: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign phase_lock_lost = st_r.lost;

    // assertion checks
    property p_pl_set;
        @(posedge sys_clk) disable iff (!rst_n)
        (phase_err > unlock_thr) && !(phase_err < lock_thr)
            |=> phase_lock_lost;
    endproperty
    a_pl_set: assert property (p_pl_set) else $error("lock loss not set");

    property p_pl_clr;
        @(posedge sys_clk) disable iff (!rst_n)
        (phase_err < lock_thr) |=> !phase_lock_lost;
    endproperty
    a_pl_clr: assert property (p_pl_clr) else $error("lock loss not cleared");
endmodule

// [sia_host_model.sv]
// host model: reads the sticky flags, then pulses the clear field
`timescale 1ns/1ps
module sia_host_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clr_req,
    input wire logic [3:0] delay,
    input wire logic [9:0] sticky_flags,
    output logic interrupt_clear,
    output logic [9:0] seen_flags
);
    ////////////////////////////////////////////////////////////////////////
    // service loop: optional stall, flag read, one-cycle write-one clear
    initial begin
        interrupt_clear = 1'b0;
        seen_flags = 10'h000;
        forever begin
            @(negedge sys_clk);
            if (rst_n && clr_req) begin
                repeat (delay) @(negedge sys_clk);
                seen_flags = sticky_flags;
                interrupt_clear = 1'b1;
                @(negedge sys_clk);
                interrupt_clear = 1'b0;
                @(negedge sys_clk);
            end
        end
    end
endmodule

// [sia_status_interrupt_aggregator_test.sv]
// self-checking bench of the status interrupt aggregator
`timescale 1ns/1ps
module sia_status_interrupt_aggregator_test;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic intr_enable = 1'b0;
    logic comb_and = 1'b0;
    logic clr_req = 1'b0;
    logic [3:0] delay = 4'h0;
    logic [8:0] live_status = 9'h000;
    logic [15:0] phase_err = 16'h0000;
    logic [15:0] lock_thr = 16'h0100;
    logic [15:0] unlock_thr = 16'h0400;
    logic [9:0] src_enable = 10'h3FF;
    logic [9:0] intr_polarity = 10'h3FF;
    logic [9:0] intr_mask = 10'h000;
    logic [7:0] pin_sel = {4'h0, sia_pkg::SEL_INTR};
    logic [1:0] pin_invert = 2'b00;
    logic [1:0] pin_open_drain = 2'b10;
    logic interrupt_clear, intr_out, interrupt_clear_busy;
    logic [9:0] sticky_flags, live_flags, seen_flags;
    logic [9:0] prev_flags = 10'h000;
    logic [9:0] notes[$];
    logic [1:0] status_pin_o, status_pin_oe;
    logic [31:0] rng = 32'hAC95B218;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    int src;
    sia_status_interrupt_aggregator dut (.sys_clk, .rst_n, .live_status,
        .phase_err, .lock_thr, .unlock_thr, .intr_enable, .src_enable,
        .intr_polarity, .intr_mask, .comb_and, .interrupt_clear, .pin_sel,
        .pin_invert, .pin_open_drain, .sticky_flags, .live_flags, .intr_out,
        .interrupt_clear_busy, .status_pin_o, .status_pin_oe);
    sia_host_model host (.sys_clk, .rst_n, .clr_req, .delay,
        .sticky_flags, .interrupt_clear, .seen_flags);
    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    // flag watcher: each flag change takes the oldest note, or counts as stray if none is queued
    always @(posedge sys_clk) begin
        #1;
        if (rst_n && sticky_flags !== prev_flags) begin
            if (notes.size() == 0)
                chk(sticky_flags, prev_flags, "stray flag change");
            else
                chk(sticky_flags, notes.pop_front(), "sticky flags");
        end
        prev_flags = sticky_flags;
    end
    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic chk(input logic [9:0] got, exp, input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // wrong-way edge first, then the edge that sets the flag
    task automatic edge_on(input int s);
        live_status[s] = ~intr_polarity[s];
        step(3);
        live_status[s] = intr_polarity[s];
    endtask
    // flags land, interrupt one cycle later, pin one more
    task automatic want(input logic [9:0] exp, input logic irq);
        int i;
        notes.push_back(exp);
        for (i = 0; i < 8 && notes.size() != 0; i++) @(negedge sys_clk);
        if (notes.size() != 0) begin
            chk(sticky_flags, exp, "flags late");
            notes.delete();
        end
        step(1);
        chk(intr_out, irq, "interrupt level");
        step(1);
        chk(status_pin_o[0], irq ^ pin_invert[0], "status pin");
    endtask
    task automatic clr(input logic [9:0] was);
        int i;
        notes.push_back(10'h000);
        clr_req = 1'b1;
        for (i = 0; i < 24 && interrupt_clear_busy !== 1'b1; i++) step(1);
        clr_req = 1'b0;
        chk(intr_out, 1'b0, "interrupt after clear");
        chk(seen_flags, was, "host read");
        step(1);
        chk(interrupt_clear_busy, 1'b0, "busy stays");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        step(20);
        rst_n = 1'b1;
        step(6);
        intr_enable = 1'b1;
        live_status[0] = 1'b1;
        want(10'h001, 1'b1);
        intr_polarity[1] = 1'b0;
        edge_on(1);
        want(10'h003, 1'b1);
        clr(10'h003);
        intr_mask = 10'h3FC;
        comb_and = 1'b1;
        live_status[2] = 1'b1;
        want(10'h004, 1'b0);
        edge_on(0);
        want(10'h005, 1'b0);
        edge_on(1);
        want(10'h007, 1'b1);
        intr_enable = 1'b0;
        edge_on(3);
        step(3);
        intr_enable = 1'b1;
        src_enable[4] = 1'b0;
        edge_on(4);
        step(4);
        chk(sticky_flags, 10'h007, "refused edges");
        phase_err = 16'hFFFF;
        want(10'h207, 1'b1);
        phase_err = 16'h0000;
        step(6);
        chk(live_flags[9], 1'b0, "phase lock regained");
        clr(10'h207);
        comb_and = 1'b0;
        intr_mask = 10'h000;
        src_enable = 10'h3FF;
        for (int k = 0; k < 8; k++) begin
            rng = xs(rng);
            src = int'(rng % 9);
            intr_polarity[src] = rng[9];
            pin_invert[0] = rng[10];
            delay = rng[3:0];
            edge_on(src);
            want(10'h001 << src, 1'b1);
            clr(10'h001 << src);
        end
        step(3);
        chk(status_pin_oe[1], !live_status[0], "open-drain enable");
        chk(status_pin_o[1], live_status[0], "pin one source");
        chk(status_pin_oe[0], 1'b1, "push-pull enable");
        // constant-low select, inverted: open drain lets the pin go
        pin_sel[7:4] = sia_pkg::SEL_ZERO;
        pin_invert[1] = 1'b1;
        step(3);
        chk(status_pin_o[1], 1'b1, "inverted low select");
        chk(status_pin_oe[1], 1'b0, "open-drain released");
        edge_on(5);
        want(10'h020, 1'b1);
        // every flag masked: no output in either gate, flag kept
        intr_mask = 10'h3FF;
        comb_and = 1'b1;
        step(3);
        chk(intr_out, 1'b0, "and with all masked");
        comb_and = 1'b0;
        step(3);
        chk(intr_out, 1'b0, "or with all masked");
        chk(sticky_flags, 10'h020, "masked flag kept");
        // clear with interrupt logic off still empties the flags
        intr_enable = 1'b0;
        clr(10'h020);
        rst_n = 1'b0;
        step(2);
        chk(sticky_flags, 10'h000, "flags in reset");
        chk(intr_out, 1'b0, "interrupt in reset");
        rst_n = 1'b1;
        step(6);
        chk(sticky_flags, 10'h000, "flags after reset");
        tally_and_finish();
    end
endmodule
